// File: dv/bms_ctrl_props.sv
// Purpose: pin and handshake checks for bms_ctrl
// Assumes: configuration held steady while out of reset
// Notes:   bound into every bms_ctrl instance below
`timescale 1ns/1ps
module bms_ctrl_props
    import bms_pkg::*;
(
    // clock, reset, requests
    input wire logic            i_clk,
    input wire logic            i_rst_b,
    input wire bms_cfg_t        i_cfg,
    input wire logic            i_req_valid,
    input wire bms_req_t        i_req,
    // handshake
    input wire logic            o_req_ready,
    input wire logic            o_req_taken,
    input wire logic            o_req_miss,
    input wire logic            o_rd_valid,
    input wire logic            o_init_done,
    // sdram pins
    input wire logic            o_base_bank_select_a_b,
    input wire logic            o_base_bank_select_b_b,
    input wire logic            o_row_strobe_shared_b,
    input wire logic            o_column_strobe_shared_b,
    input wire logic            o_write_enable_shared_b,
    input wire logic [MA_W-1:0] o_muxed_address_bus,
    input wire logic            o_memory_data_bus_oe_b
);
    logic [2:0] cmd;
    logic [2:0] cl;
    int         split;
    assign cmd = {o_row_strobe_shared_b, o_column_strobe_shared_b,
                  o_write_enable_shared_b};
    assign cl = i_cfg.cas_latency_select ? MODE_CL2 : MODE_CL3;
    // upper select sits on the highest address bit left undecoded
    assign split = SEL_LSB + MASK_W - $countones(i_cfg.size_mask);

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    ready_after_init_a: assert property (
        o_req_ready |-> o_init_done) else $error("ready before mode set");
    one_answer_a: assert property (
        o_req_ready && i_req_valid |=> (o_req_taken ^ o_req_miss)
        && !o_req_ready) else $error("request not answered once");
    miss_quiet_a: assert property (
        o_req_miss |-> cmd == CMD_NOP) else $error("command on a miss");
    bank_bit_a: assert property (
        o_req_taken && cmd == CMD_ACT |-> o_muxed_address_bus[BANK_BIT]
        == $past(i_req.addr[BANK_BIT])) else $error("bank bit wrong");
    upper_select_a: assert property (
        o_req_taken && cmd == CMD_ACT |-> o_base_bank_select_b_b
        == !$past(i_req.addr[split])) else $error("select split wrong");
    one_select_a: assert property (
        o_init_done && cmd == CMD_ACT |-> o_base_bank_select_a_b
        != o_base_bank_select_b_b) else $error("not one select low");
    full_burst_a: assert property (
        cmd == CMD_RD |=> (cmd == CMD_NOP)[*8]) else $error("read cut");
    write_stop_a: assert property (
        cmd == CMD_WR |-> ##[1:40] (cmd == CMD_BST || cmd == CMD_PRE))
        else $error("write burst not ended");
    write_drive_a: assert property (
        cmd == CMD_WR |-> !o_memory_data_bus_oe_b) else $error("no drive");
    mode_word_a: assert property (
        cmd == CMD_MRS |-> o_muxed_address_bus ==
        {5'h00, cl, MODE_INTLV, MODE_BL8}) else $error("mode word wrong");

    cover property (o_req_miss);
    cover property (cmd == CMD_BST);
    cover property (o_req_taken && o_rd_valid);
    cover property (cmd == CMD_ACT && !o_base_bank_select_b_b);
endmodule

bind bms_ctrl bms_ctrl_props i_props (
    .i_clk, .i_rst_b, .i_cfg, .i_req_valid, .i_req, .o_req_ready,
    .o_req_taken, .o_req_miss, .o_rd_valid, .o_init_done,
    .o_base_bank_select_a_b, .o_base_bank_select_b_b,
    .o_row_strobe_shared_b, .o_column_strobe_shared_b,
    .o_write_enable_shared_b, .o_muxed_address_bus,
    .o_memory_data_bus_oe_b
);

// File: dv/bms_sdram_model.sv
// Purpose: behavioural bank of sdram chips on the base bus
// Assumes: one row open at a time, bursts of eight
// Notes:   unwritten words read back as unknown
`timescale 1ns/1ps
module bms_sdram_model
    import bms_pkg::*;
(
    input  wire logic            i_clk,
    // shared strobes, selects and masks
    input  wire logic            i_sel_a_b,
    input  wire logic            i_sel_b_b,
    input  wire logic [2:0]      i_cmd,
    input  wire logic [3:0]      i_dqm,
    input  wire logic [MA_W-1:0] i_ma,
    // data
    input  wire logic [31:0]     i_dq,
    input  wire logic            i_dq_oe_b,
    output logic [31:0]          o_dq
);
    logic [31:0]     mem [int];
    logic [MA_W-1:0] row;
    logic [8:0]      col;
    logic [2:0]      cl = 3'h3;
    int              cyc = 0;
    int              t_rd = -99;
    int              wbeat = 8;
    int              k;

    function automatic int key(input int beat);
        return {row, col[8:3], col[2:0] ^ 3'(beat)};
    endfunction

    initial o_dq = 32'h0;

    always @(posedge i_clk)
    begin
        cyc = cyc + 1;
        if (!(i_sel_a_b && i_sel_b_b))
        begin
            case (i_cmd)
                CMD_MRS: cl = i_ma[6:4];
                CMD_ACT: row = i_ma;
                CMD_RD:
                begin
                    col  = i_ma[8:0];
                    t_rd = cyc;
                end
                CMD_WR:
                begin
                    col   = i_ma[8:0];
                    wbeat = 0;
                end
                CMD_BST, CMD_PRE: wbeat = 8;
                default: ;
            endcase
        end
        if (wbeat < 8)
        begin
            for (int b = 0; b < 4; b++)
                if (!i_dqm[b] && !i_dq_oe_b)
                    mem[key(wbeat)][8*b+:8] = i_dq[8*b+:8];
            wbeat = wbeat + 1;
        end
        #1;
        k = cyc - t_rd - int'(cl) + 1;
        // released bus shows the inverse, never a stale copy
        o_dq = (k >= 0 && k < 8) ? mem[key(k)] : ~o_dq;
    end
endmodule

// File: dv/bms_tb.sv
// Purpose: self-checking bench for bms_ctrl
// Assumes: short power-up wait, runs far short of refresh interval
// Notes:   expected data kept in a shadow of written words
`timescale 1ns/1ps
module testbench;
    import bms_pkg::*;
    logic                  i_clk, i_rst_b, i_req_valid;
    bms_cfg_t              i_cfg;
    bms_req_t              i_req;
    logic                  o_req_ready, o_req_taken, o_req_miss;
    logic                  o_req_done, o_rd_valid, o_init_done;
    logic [2:0]            o_rd_index;
    logic [31:0]           o_rd_data, i_memory_data_bus;
    logic [31:0]           o_memory_data_bus;
    logic                  o_base_bank_select_a_b, o_base_bank_select_b_b;
    logic                  o_row_strobe_shared_b, o_column_strobe_shared_b;
    logic                  o_write_enable_shared_b, o_memory_data_bus_oe_b;
    logic [3:0]            o_data_byte_mask;
    logic [MA_W-1:0]       o_muxed_address_bus;
    int                    fail_count = 0;
    int                    n_compared = 0;
    logic [31:0]           shadow [int];
    logic [AW-1:0]         lines [4];
    logic [3:0]            w;
    logic [LINE-1:0][3:0]  be;

    bms_ctrl #(.PWRUP_CYC(20)) i_dut (
        .i_clk, .i_rst_b, .i_cfg, .i_req_valid, .i_req, .o_req_ready,
        .o_req_taken, .o_req_miss, .o_req_done, .o_rd_valid, .o_rd_index,
        .o_rd_data, .o_init_done, .o_base_bank_select_a_b,
        .o_base_bank_select_b_b, .o_row_strobe_shared_b,
        .o_column_strobe_shared_b, .o_write_enable_shared_b,
        .o_data_byte_mask, .o_muxed_address_bus, .i_memory_data_bus,
        .o_memory_data_bus, .o_memory_data_bus_oe_b
    );

    bms_sdram_model i_mem (
        .i_clk(i_clk), .i_sel_a_b(o_base_bank_select_a_b),
        .i_sel_b_b(o_base_bank_select_b_b),
        .i_cmd({o_row_strobe_shared_b, o_column_strobe_shared_b,
                o_write_enable_shared_b}),
        .i_dqm(o_data_byte_mask), .i_ma(o_muxed_address_bus),
        .i_dq(o_memory_data_bus), .i_dq_oe_b(o_memory_data_bus_oe_b),
        .o_dq(i_memory_data_bus)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask

    task automatic tally_and_finish;
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic exp_hit(input logic [AW-1:0] a);
        return ((a[27:22] ^ i_cfg.base_match_field)
                & {2'h3, i_cfg.size_mask}) == 6'h00;
    endfunction

    // entered and left 1 ns after a rising edge
    task automatic do_req(input logic wr, input logic [3:0] words,
                          input logic [AW-1:0] addr,
                          input logic [LINE-1:0][3:0] en);
        int         n;
        int         k;
        logic [2:0] s;
        logic [2:0] x;
        bms_req_t   r;
        @(posedge i_clk);
        #1;
        s = addr[4:2];
        r.wr = wr;
        r.words = words;
        r.addr = addr;
        r.be = en;
        for (int i = 0; i < LINE; i++)
            r.data[i] = $urandom;
        i_req = r;
        i_req_valid = 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            #1;
            n++;
        end while (o_req_taken !== 1'b1 && o_req_miss !== 1'b1 && n < 300);
        i_req_valid = 1'b0;
        check(o_req_miss === !exp_hit(addr), "hit decode");
        if (o_req_miss === 1'b1)
            return;
        for (int i = 0; i < words && wr; i++)
        begin
            x = s ^ 3'(i);
            for (int b = 0; b < 4; b++)
                if (en[x][b])
                    shadow[{addr[AW-1:5], x}][8*b+:8] = r.data[x][8*b+:8];
        end
        k = 0;
        n = 0;
        forever
        begin
            if (o_rd_valid === 1'b1)
            begin
                x = s ^ 3'(k);
                check(o_rd_index === x, "beat order");
                check(o_rd_data === shadow[{addr[AW-1:5], x}], "data");
                k++;
            end
            if (o_req_done === 1'b1 || n > 300)
                break;
            @(posedge i_clk);
            #1;
            n++;
        end
        check(o_req_done === 1'b1, "hung");
        check(k == (wr ? 0 : int'(words)), "word count");
    endtask

    initial
    begin
        #200000;
        fail_count++;
        $display("mismatch %0t watchdog", $time);
        tally_and_finish();
    end

    initial
    begin
        void'($urandom(32'h8ca488f0));
        i_rst_b = 1'b0;
        i_req_valid = 1'b0;
        i_req = '0;
        i_cfg = '0;
        for (int run = 0; run < 2; run++)
        begin
            // page mode stays off with sdram
            i_cfg = '{1'b0, run ? 4'h0 : 4'hC, 6'h14, run[0]};
            i_rst_b = 1'b0;
            repeat (12) @(posedge i_clk);
            #1;
            i_rst_b = 1'b1;
            for (int n = 0; n < 300 && o_init_done !== 1'b1; n++)
                @(posedge i_clk);
            @(posedge i_clk);
            #1;
            check(o_init_done === 1'b1, "init not done");
            for (int i = 0; i < 4; i++)
            begin
                lines[i] = {6'h14, 22'h0} | AW'($urandom & 32'h00FFFFE0);
                lines[i][23] = i[0];
                do_req(1'b1, 4'h8, lines[i], '1);
            end
            repeat (24)
            begin
                w = 4'h1 << ($urandom % 4);
                be = $urandom;
                do_req(1'($urandom), w, lines[$urandom % 4]
                       | AW'((($urandom % 8) & ~(w - 1)) << 2), be);
            end
            do_req(1'b0, 4'h1, lines[0], '1);
            do_req(1'b1, 4'h1, lines[0] + 4, '1);
            do_req(1'b0, 4'h1, lines[0] + 4, '1);
            do_req(1'b0, 4'h1, lines[0] + 12, '1);
            do_req(1'b0, 4'h1, lines[2] ^ 28'h8000000, '1);
            do_req(1'b1, 4'h2, lines[1] ^ 28'h0400000, 32'h0000005A);
        end
        tally_and_finish();
    end
endmodule

// File: verilog/bms_ctrl.sv
// Purpose: base memory sdram access, one bank behind two chip selects
// Assumes: requester holds i_req stable while i_req_valid is high
// Notes:   no refresh engine; no page mode with sdram
`timescale 1ns/1ps
module bms_ctrl
    import bms_pkg::*;
#(
    parameter int unsigned PWRUP_CYC = T_PWRUP_US * CLK_MHZ
)
(
    // clock and reset
    input  wire logic            i_clk,
    input  wire logic            i_rst_b,
    // configuration
    input  wire bms_cfg_t        i_cfg,
    // request from cpu or pci master
    input  wire logic            i_req_valid,
    input  wire bms_req_t        i_req,
    output logic                 o_req_ready,
    output logic                 o_req_taken,
    output logic                 o_req_miss,
    output logic                 o_req_done,
    // read return
    output logic                 o_rd_valid,
    output logic [2:0]           o_rd_index,
    output logic [31:0]          o_rd_data,
    // status
    output logic                 o_init_done,
    // sdram pins
    output logic                 o_base_bank_select_a_b,
    output logic                 o_base_bank_select_b_b,
    output logic                 o_row_strobe_shared_b,
    output logic                 o_column_strobe_shared_b,
    output logic                 o_write_enable_shared_b,
    output logic [3:0]           o_data_byte_mask,
    output logic [MA_W-1:0]      o_muxed_address_bus,
    input  wire logic [31:0]     i_memory_data_bus,
    output logic [31:0]          o_memory_data_bus,
    output logic                 o_memory_data_bus_oe_b
);

    typedef struct packed {
        bms_state_t          st;
        logic [CW-1:0]       cnt;
        logic [3:0]          beat;
        logic [2:0]          cl;
        bms_req_t            req;
        logic                upper;
        bms_pins_t           pin;
        logic                ready;
        logic                taken;
        logic                miss;
        logic                done;
        logic                rd_valid;
        logic [2:0]          rd_index;
        logic [31:0]         rd_data;
        logic                init_done;
        logic [1:0]          pf_v;
        logic [1:0][AW-3:0]  pf_addr;
        logic [1:0][31:0]    pf_data;
    } bms_s_t;

    localparam bms_pins_t PIN_IDLE = '{
        sel_a_b: 1'h1, sel_b_b: 1'h1, cmd: CMD_NOP, dqm: 4'hF,
        ma: '0, dq: '0, dq_oe_b: 1'h1};

    localparam bms_s_t S_RST = '{
        st: ST_PWRUP, cnt: CW'(PWRUP_CYC), pin: PIN_IDLE, default: '0};

    bms_s_t        s_r;
    bms_s_t        s_nxt;
    logic          hit;
    logic          upper;
    logic [2:0]    widx;
    logic [2:0]    start;
    logic [AW-3:0] waddr;
    logic          pf_e;

    bms_decode u_decode
    (
        .i_addr  (i_req.addr),
        .i_cfg   (i_cfg),
        .o_hit   (hit),
        .o_upper (upper)
    );

    // 16 MB of eight by-four chips is not decodable here; software keeps
    // the size mask to the supported organisations

    assign start = s_r.req.addr[WSEL_LSB +: 3];
    assign widx  = start ^ s_r.beat[2:0];
    assign waddr = {s_r.req.addr[AW-1:COL_LSB], widx};
    assign pf_e  = 1'(s_r.beat - s_r.req.words);

    always_comb
    begin
        s_nxt          = s_r;
        s_nxt.pin      = PIN_IDLE;
        s_nxt.taken    = 1'h0;
        s_nxt.miss     = 1'h0;
        s_nxt.done     = 1'h0;
        s_nxt.rd_valid = 1'h0;
        if (s_r.cnt != '0)
        begin
            s_nxt.cnt = s_r.cnt - CW'(1);
        end
        unique case (s_r.st)
            ST_PWRUP:
            begin
                if (s_r.cnt == '0)
                begin
                    // both selects low: every chip sees the same sequence
                    s_nxt.pin.sel_a_b        = 1'h0;
                    s_nxt.pin.sel_b_b        = 1'h0;
                    s_nxt.pin.cmd            = CMD_PRE;
                    s_nxt.pin.ma[PALL_BIT]   = 1'h1;
                    s_nxt.cnt                = RP_CYC;
                    s_nxt.st                 = ST_PREALL;
                end
            end
            ST_PREALL, ST_REF:
            begin
                if (s_r.cnt == '0)
                begin
                    s_nxt.pin.sel_a_b = 1'h0;
                    s_nxt.pin.sel_b_b = 1'h0;
                    if (s_r.st == ST_REF &&
                        s_r.beat == 4'(REF_COUNT - 1))
                    begin
                        // latency is fixed into the chips here only
                        s_nxt.cl = i_cfg.cas_latency_select ?
                            MODE_CL2 : MODE_CL3;
                        s_nxt.pin.cmd     = CMD_MRS;
                        s_nxt.pin.ma      = {5'h0, s_nxt.cl,
                            MODE_INTLV, MODE_BL8};
                        s_nxt.cnt         = MRD_CYC;
                        s_nxt.beat        = 4'h0;
                        s_nxt.st          = ST_MRS;
                    end
                    else
                    begin
                        s_nxt.pin.cmd = CMD_REF;
                        s_nxt.cnt     = RC_CYC;
                        if (s_r.st == ST_REF)
                        begin
                            s_nxt.beat = s_r.beat + 4'h1;
                        end
                        s_nxt.st = ST_REF;
                    end
                end
            end
            ST_MRS:
            begin
                if (s_r.cnt == '0)
                begin
                    s_nxt.init_done = 1'h1;
                    s_nxt.ready     = 1'h1;
                    s_nxt.st        = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                s_nxt.ready = 1'h1;
                if (s_r.ready && i_req_valid)
                begin
                    s_nxt.ready = 1'h0;
                    if (!hit)
                    begin
                        s_nxt.miss = 1'h1;
                    end
                    else if (!i_req.wr && i_req.words == 4'h1 &&
                        ((s_r.pf_v[0] && s_r.pf_addr[0] ==
                          i_req.addr[AW-1:WSEL_LSB]) ||
                         (s_r.pf_v[1] && s_r.pf_addr[1] ==
                          i_req.addr[AW-1:WSEL_LSB])))
                    begin
                        // single word already held: no sdram cycle
                        s_nxt.taken    = 1'h1;
                        s_nxt.done     = 1'h1;
                        s_nxt.rd_valid = 1'h1;
                        s_nxt.rd_index = i_req.addr[WSEL_LSB +: 3];
                        s_nxt.rd_data  = (s_r.pf_v[0] &&
                            s_r.pf_addr[0] == i_req.addr[AW-1:WSEL_LSB])
                            ? s_r.pf_data[0] : s_r.pf_data[1];
                    end
                    else
                    begin
                        s_nxt.taken = 1'h1;
                        s_nxt.req   = i_req;
                        s_nxt.upper = upper;
                        s_nxt.pf_v  = 2'h0;
                        s_nxt.pin.sel_a_b = upper;
                        s_nxt.pin.sel_b_b = !upper;
                        s_nxt.pin.cmd     = CMD_ACT;
                        s_nxt.pin.ma      = {i_req.addr[BANK_BIT],
                            i_req.addr[ROW_LSB +: ROW_W]};
                        s_nxt.cnt         = RCD_CYC;
                        s_nxt.st          = ST_ACT;
                    end
                end
            end
            ST_ACT:
            begin
                if (s_r.cnt == '0)
                begin
                    s_nxt.pin.sel_a_b = s_r.upper;
                    s_nxt.pin.sel_b_b = !s_r.upper;
                    s_nxt.pin.ma      = {s_r.req.addr[BANK_BIT], 2'h0,
                        s_r.req.addr[COL_LSB +: COL_W], start};
                    s_nxt.beat        = 4'h1;
                    if (s_r.req.wr)
                    begin
                        s_nxt.pin.cmd     = CMD_WR;
                        s_nxt.pin.dq      = s_r.req.data[start];
                        s_nxt.pin.dqm     = ~s_r.req.be[start];
                        s_nxt.pin.dq_oe_b = 1'h0;
                        s_nxt.st          = ST_WR;
                    end
                    else
                    begin
                        s_nxt.pin.cmd = CMD_RD;
                        s_nxt.pin.dqm = 4'h0;
                        s_nxt.beat    = 4'h0;
                        s_nxt.cnt     = CW'(s_r.cl);
                        s_nxt.st      = ST_RD;
                    end
                end
            end
            ST_RD:
            begin
                s_nxt.pin.sel_a_b = s_r.upper;
                s_nxt.pin.sel_b_b = !s_r.upper;
                s_nxt.pin.dqm     = 4'h0;
                if (s_r.cnt == '0)
                begin
                    // whole burst always taken off the bus
                    s_nxt.beat = s_r.beat + 4'h1;
                    if (s_r.beat < s_r.req.words)
                    begin
                        s_nxt.rd_valid = 1'h1;
                        s_nxt.rd_index = widx;
                        s_nxt.rd_data  = i_memory_data_bus;
                    end
                    else if (s_r.beat < s_r.req.words + 4'h2)
                    begin
                        s_nxt.pf_v[pf_e]    = 1'h1;
                        s_nxt.pf_addr[pf_e] = waddr;
                        s_nxt.pf_data[pf_e] = i_memory_data_bus;
                    end
                    if (s_r.beat == 4'(LINE - 1))
                    begin
                        s_nxt.cnt = '0;
                        s_nxt.st  = ST_TERM;
                    end
                end
            end
            ST_WR:
            begin
                s_nxt.pin.sel_a_b = s_r.upper;
                s_nxt.pin.sel_b_b = !s_r.upper;
                if (s_r.beat < s_r.req.words)
                begin
                    s_nxt.pin.dq      = s_r.req.data[widx];
                    s_nxt.pin.dqm     = ~s_r.req.be[widx];
                    s_nxt.pin.dq_oe_b = 1'h0;
                    s_nxt.beat        = s_r.beat + 4'h1;
                end
                else
                begin
                    // cut a short burst so no extra word is stored
                    if (s_r.req.words != 4'(LINE))
                    begin
                        s_nxt.pin.cmd = CMD_BST;
                    end
                    s_nxt.cnt = WR_CYC;
                    s_nxt.st  = ST_TERM;
                end
            end
            ST_TERM:
            begin
                // precharge goes to bank 0 only; a row opened with BANK_BIT high stays open
                if (s_r.cnt == '0 && s_r.beat != 4'h0)
                begin
                    s_nxt.pin.sel_a_b = s_r.upper;
                    s_nxt.pin.sel_b_b = !s_r.upper;
                    s_nxt.pin.cmd     = CMD_PRE;
                    s_nxt.beat        = 4'h0;
                    s_nxt.cnt         = RP_CYC;
                end
                else if (s_r.cnt == '0)
                begin
                    s_nxt.done  = 1'h1;
                    s_nxt.ready = 1'h1;
                    s_nxt.st    = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            s_r <= S_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign o_req_ready              = s_r.ready;
    assign o_req_taken              = s_r.taken;
    assign o_req_miss               = s_r.miss;
    assign o_req_done               = s_r.done;
    assign o_rd_valid               = s_r.rd_valid;
    assign o_rd_index               = s_r.rd_index;
    assign o_rd_data                = s_r.rd_data;
    assign o_init_done              = s_r.init_done;
    assign o_base_bank_select_a_b   = s_r.pin.sel_a_b;
    assign o_base_bank_select_b_b   = s_r.pin.sel_b_b;
    assign o_row_strobe_shared_b    = s_r.pin.cmd[2];
    assign o_column_strobe_shared_b = s_r.pin.cmd[1];
    assign o_write_enable_shared_b  = s_r.pin.cmd[0];
    assign o_data_byte_mask         = s_r.pin.dqm;
    assign o_muxed_address_bus      = s_r.pin.ma;
    assign o_memory_data_bus        = s_r.pin.dq;
    assign o_memory_data_bus_oe_b   = s_r.pin.dq_oe_b;

endmodule

// File: verilog/bms_decode.sv
// Purpose: base range hit and chip select split for one address
// Assumes: size mask is left-justified ones
// Notes:   purely combinational
`timescale 1ns/1ps
module bms_decode
    import bms_pkg::*;
(
    // address and configuration
    input  wire logic [AW-1:0] i_addr,
    input  wire bms_cfg_t      i_cfg,
    // decode result
    output logic               o_hit,
    output logic               o_upper
);

    logic [HIT_W-1:0] match;
    logic [2:0]       zeros;

    // masked bits always compare true; bits 27:26 are never masked
    genvar gi;
    generate
        for (gi = 0; gi < HIT_W; gi++)
        begin : g_cmp
            if (gi < MASK_W)
            begin : g_m
                assign match[gi] = !i_cfg.size_mask[gi] ||
                    (i_addr[HIT_LSB+gi] == i_cfg.base_match_field[gi]);
            end
            else
            begin : g_d
                assign match[gi] =
                    (i_addr[HIT_LSB+gi] == i_cfg.base_match_field[gi]);
            end
        end
    endgenerate

    assign o_hit = &match;

    // the halves split on the bit just below the decoded region
    always_comb
    begin
        zeros = 3'h0;
        for (int i = 0; i < MASK_W; i++)
        begin
            if (!i_cfg.size_mask[i])
            begin
                zeros = zeros + 3'h1;
            end
        end
        o_upper = i_addr[SEL_LSB + int'(zeros)];
    end

endmodule

// File: verilog/bms_pkg.sv
// Purpose: shared constants and carriers for the base sdram access block
// Assumes: 250 MHz core clock, sdram inputs synchronous to it
// Notes:   one base bank, 32-bit data, burst of eight, interleaved only
package bms_pkg;

    // clock and timing, times in ns, us or clocks as printed for typical parts
    localparam int CLK_MHZ    = 250;
    localparam int T_PWRUP_US = 100;
    localparam int T_RP_NS    = 20;
    localparam int T_RCD_NS   = 20;
    localparam int T_RC_NS    = 70;
    localparam int T_WR_NS    = 15;
    localparam int T_MRD_CK   = 2;
    localparam int REF_COUNT  = 2;
    localparam int CW         = 15;

    localparam logic [CW-1:0] RP_CYC  = CW'((T_RP_NS*CLK_MHZ+999)/1000);
    localparam logic [CW-1:0] RCD_CYC = CW'((T_RCD_NS*CLK_MHZ+999)/1000);
    localparam logic [CW-1:0] RC_CYC  = CW'((T_RC_NS*CLK_MHZ+999)/1000);
    localparam logic [CW-1:0] WR_CYC  = CW'((T_WR_NS*CLK_MHZ+999)/1000);
    localparam logic [CW-1:0] MRD_CYC = CW'(T_MRD_CK);

    // command codes {row, column, write}, active low
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_MRS = 3'h0;

    // mode register fields
    localparam logic [2:0] MODE_BL8   = 3'h3;
    localparam logic       MODE_INTLV = 1'h1;
    localparam logic [2:0] MODE_CL2   = 3'h2;
    localparam logic [2:0] MODE_CL3   = 3'h3;

    // address layout
    localparam int MA_W     = 12;
    localparam int BANK_BIT = 11;
    localparam int PALL_BIT = 10;
    localparam int ROW_LSB  = 12;
    localparam int ROW_W    = 11;
    localparam int COL_LSB  = 5;
    localparam int COL_W    = 6;
    localparam int WSEL_LSB = 2;
    localparam int HIT_LSB  = 22;
    localparam int HIT_W    = 6;
    localparam int MASK_W   = 4;
    localparam int SEL_LSB  = 21;
    localparam int AW       = 28;
    localparam int LINE     = 8;

    typedef struct packed {
        logic                  wr;
        logic [3:0]            words;
        logic [AW-1:0]         addr;
        logic [LINE-1:0][31:0] data;
        logic [LINE-1:0][3:0]  be;
    } bms_req_t;

    typedef struct packed {
        logic              page_mode_enable;
        logic [MASK_W-1:0] size_mask;
        logic [HIT_W-1:0]  base_match_field;
        logic              cas_latency_select;
    } bms_cfg_t;

    typedef struct packed {
        logic            sel_a_b;
        logic            sel_b_b;
        logic [2:0]      cmd;
        logic [3:0]      dqm;
        logic [MA_W-1:0] ma;
        logic [31:0]     dq;
        logic            dq_oe_b;
    } bms_pins_t;

    typedef enum logic [8:0] {
        ST_PWRUP = 9'h001,
        ST_PREALL = 9'h002,
        ST_REF   = 9'h004,
        ST_MRS   = 9'h008,
        ST_IDLE  = 9'h010,
        ST_ACT   = 9'h020,
        ST_RD    = 9'h040,
        ST_WR    = 9'h080,
        ST_TERM  = 9'h100
    } bms_state_t;

endpackage
